// >>> hdl/ibr_pkg.sv
package ibr_pkg;

    localparam int unsigned DATA_W          = 16;
    localparam int unsigned ADDR_W          = 16;
    localparam int unsigned BLOCK_WORDS     = 10;
    localparam int unsigned BUF_BLOCKS      = 64;
    localparam int unsigned BUF_WORDS       = 640;
    localparam int unsigned RANGE_W         = 20;
    localparam int unsigned TIME_W          = 16;
    localparam int unsigned CNT_W           = 7;

    // Range counter rate as a fraction of the 20 MHz system clock
    localparam int unsigned CLK_FREQ_MHZ    = 20;
    localparam int unsigned RANGE_FREQ_MHZ  = 16;
    localparam logic [4:0]  RANGE_STEP      = 5'(RANGE_FREQ_MHZ);
    localparam logic [4:0]  RANGE_MOD       = 5'(CLK_FREQ_MHZ);

    // Wishbone register offsets (byte addresses)
    localparam logic [7:0]  OFS_A_PORT      = 8'h00;
    localparam logic [7:0]  OFS_C_PORT      = 8'h04;
    localparam logic [7:0]  OFS_CTRL        = 8'h08;

    // Control write bits and status read bits
    localparam int unsigned CTRL_START_BIT  = 0;
    localparam int unsigned CTRL_CLEAR_BIT  = 1;
    localparam int unsigned CTRL_P_BIT      = 2;
    localparam int unsigned STAT_BUSY_BIT   = 0;
    localparam int unsigned STAT_DONE_BIT   = 1;
    localparam int unsigned STAT_ARR_BIT    = 2;
    localparam int unsigned STAT_IDIS_BIT   = 3;

    // Reset values
    localparam logic [ADDR_W-1:0] ORIGIN_RST = 16'h0000;
    localparam logic [CNT_W-1:0]  COUNT_RST  = 7'h00;

    typedef enum logic [0:0] {
        IBR_ST_IDLE  = 1'b0,
        IBR_ST_WRITE = 1'b1
    } ibr_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ibr_dma_s;

endpackage : ibr_pkg

// >>> hdl/ibr_receiver_port.sv
`timescale 1ns/1ps
// Behaviour
// - Start pulse sets busy and clears done.
// - Clear pulse resets busy and done; system reset also clears interrupt disable.
// - Interrupt requested whenever a done flag is set and disable is zero.
// - Mask-out pulse loads interrupt disable from one assigned data bit.
// - Transfers and start, clear and P pulses act only when addressed; system reset and mask-out act always.
// - Each interrogation stores a ten-word block into host memory.
// - Buffer is a fixed 640-word region of 64 blocks.
// - Block counter increments only when the tenth word is stored.
// - After the 64th block the address wraps to the buffer origin.
// - Counter overflow at 64 blocks sets done and clears busy.
// - Arrival event comes at detection, before the block completes.
// - Each arrival while busy sets a second done flag; busy stays set.
// - Skip test shows standard done; identity shows either done flag.
// - P pulse clears the arrival done flag; host issues it first.
// - Clear or system reset zeroes busy, both done flags, counter; an arrival while busy in the same cycle still sets the arrival flag.
// - C-port read returns block count; host polls until nonzero.
// - C-port write decrements a nonzero count, data ignored.
// - Each time busy sets, address reloads to buffer origin.
// - 20-bit range counter at 16 MHz; low or high 16 bits as time.
// - A-port read returns the next memory address to be written.
module ibr_receiver_port #(
    parameter int unsigned MASK_BIT = 5
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [7:0]                   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    input  wire logic                         system_io_reset_pulse_i,
    input  wire logic                         mask_out_i,
    input  wire logic [ibr_pkg::DATA_W-1:0]   mask_data_i,
    input  wire logic                         arrival_i,
    input  wire logic                         word_valid_i,
    input  wire logic [ibr_pkg::DATA_W-1:0]   word_i,
    output logic                              word_ready_o,
    output logic                              dma_req_o,
    output ibr_pkg::ibr_dma_s                 dma_o,
    input  wire logic                         dma_ack_i,
    output logic                              intr_o,
    output logic                              skip_done_o,
    output logic                              interrupt_acknowledge_query_ident_o,
    output logic      [ibr_pkg::TIME_W-1:0]   time_disc_o,
    output logic      [ibr_pkg::TIME_W-1:0]   time_short_o
);
    import ibr_pkg::*;

    logic                 ack_q;
    logic [31:0]          rdat_q;
    logic                 busy_q;
    logic                 done_q;
    logic                 arr_q;
    logic                 idis_q;
    logic [ADDR_W-1:0]    origin_q;
    logic [ADDR_W-1:0]    offset_q;
    logic [3:0]           wcnt_q;
    logic [CNT_W-1:0]     count_q;
    logic [CNT_W-1:0]     count_d;
    logic [RANGE_W-1:0]   range_q;
    logic [4:0]           frac_q;
    logic [5:0]           frac_sum;
    ibr_state_e           st_q;
    ibr_dma_s             dma_q;
    logic                 req_q;
    logic                 rdy_q;
    logic                 intr_q;
    logic                 wr_fire;
    logic                 ctrl_wr;
    logic                 start_p;
    logic                 clear_p;
    logic                 p_p;
    logic                 dec_p;
    logic                 take;
    logic                 word_done;
    logic                 blk_done;
    logic                 inc;
    logic                 dec;
    logic                 ovf;
    logic                 kill;
    logic                 busy_d;
    logic                 done_d;
    logic                 arr_d;
    logic                 ident_q;
    logic [31:0]          rdat_d;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    function automatic logic [31:0] stat_word(input logic b, input logic d,
                                              input logic a, input logic i);
        stat_word                = 32'h0000_0000;
        stat_word[STAT_BUSY_BIT] = b;
        stat_word[STAT_DONE_BIT] = d;
        stat_word[STAT_ARR_BIT]  = a;
        stat_word[STAT_IDIS_BIT] = i;
    endfunction : stat_word

    // Write acts at the acknowledging edge only
    assign wr_fire   = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    assign ctrl_wr   = wr_fire && hit(wb_adr_i, OFS_CTRL);
    assign start_p   = ctrl_wr && wb_dat_i[CTRL_START_BIT];
    assign clear_p   = ctrl_wr && wb_dat_i[CTRL_CLEAR_BIT];
    assign p_p       = ctrl_wr && wb_dat_i[CTRL_P_BIT];
    assign dec_p     = wr_fire && hit(wb_adr_i, OFS_C_PORT);
    // Clear and system reset beat a start in the same cycle
    assign kill      = clear_p || system_io_reset_pulse_i;

    assign take      = word_valid_i && rdy_q;
    assign word_done = (st_q == IBR_ST_WRITE) && dma_ack_i && !kill;
    assign blk_done  = word_done && (wcnt_q == 4'(BLOCK_WORDS - 1));
    assign inc       = blk_done;
    assign dec       = dec_p && (count_q != COUNT_RST);
    assign ovf       = inc && !dec && (count_q == CNT_W'(BUF_BLOCKS - 1));

    // Read data is chosen ahead so it stands together with the acknowledge
    always_comb begin
        rdat_d = 32'h0000_0000;
        if (hit(wb_adr_i, OFS_A_PORT)) begin
            rdat_d[ADDR_W-1:0] = origin_q + offset_q;
        end else if (hit(wb_adr_i, OFS_C_PORT)) begin
            rdat_d[CNT_W-1:0] = count_q;
        end else if (hit(wb_adr_i, OFS_CTRL)) begin
            rdat_d = stat_word(busy_q, done_q, arr_q, idis_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else begin
            rdat_q <= rdat_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            origin_q <= ORIGIN_RST;
        end else if (wr_fire && hit(wb_adr_i, OFS_A_PORT)) begin
            origin_q <= wb_dat_i[ADDR_W-1:0];
        end
    end

    // Busy and standard done; a clear blocks word_done, so the clear wins over an overflow set
    always_comb begin
        busy_d = busy_q;
        done_d = done_q;
        if (ovf) begin
            busy_d = 1'b0;
            done_d = 1'b1;
        end else if (kill) begin
            busy_d = 1'b0;
            done_d = 1'b0;
        end else if (start_p) begin
            busy_d = 1'b1;
            done_d = 1'b0;
        end
    end

    // Arrival flag leaves busy alone so reception keeps running
    always_comb begin
        arr_d = arr_q;
        if (arrival_i && busy_q) begin
            arr_d = 1'b1;
        end else if (kill || p_p) begin
            arr_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arr_q <= 1'b0;
        end else begin
            arr_q <= arr_d;
        end
    end

    // Own flop from next values, so it tracks both done flags without lag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ident_q <= 1'b0;
        end else begin
            ident_q <= done_d || arr_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || system_io_reset_pulse_i) begin
            idis_q <= 1'b0;
        end else if (mask_out_i) begin
            idis_q <= mask_data_i[MASK_BIT];
        end
    end

    always_comb begin
        count_d = count_q;
        if (inc && !dec) begin
            count_d = count_q + CNT_W'(1);
        end else if (dec && !inc) begin
            count_d = count_q - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || kill) begin
            count_q <= COUNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    // Address offset and word position within a block
    always_ff @(posedge clk_i) begin
        if (rst_i || kill || (start_p && !busy_q)) begin
            offset_q <= '0;
        end else if (word_done) begin
            if (offset_q == ADDR_W'(BUF_WORDS - 1)) begin
                offset_q <= '0;
            end else begin
                offset_q <= offset_q + ADDR_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || kill || (start_p && !busy_q)) begin
            wcnt_q <= 4'h0;
        end else if (blk_done) begin
            wcnt_q <= 4'h0;
        end else if (word_done) begin
            wcnt_q <= wcnt_q + 4'h1;
        end
    end

    // Data channel writer, one word at a time
    always_ff @(posedge clk_i) begin
        if (rst_i || kill) begin
            st_q  <= IBR_ST_IDLE;
            req_q <= 1'b0;
        end else begin
            case (st_q)
                IBR_ST_IDLE: begin
                    if (take) begin
                        st_q  <= IBR_ST_WRITE;
                        req_q <= 1'b1;
                    end
                end
                IBR_ST_WRITE: begin
                    if (dma_ack_i) begin
                        st_q  <= IBR_ST_IDLE;
                        req_q <= 1'b0;
                    end
                end
                default: begin
                    st_q  <= IBR_ST_IDLE;
                    req_q <= 1'b0;
                end
            endcase
        end
    end

    // Word and address are held unchanged for the memory until acknowledged
    always_ff @(posedge clk_i) begin
        if (rst_i || kill) begin
            dma_q <= '0;
        end else if (take && (st_q == IBR_ST_IDLE)) begin
            dma_q.addr <= origin_q + offset_q;
            dma_q.data <= word_i;
        end
    end

    // Ready drops while a word is in flight or storage has stopped
    always_ff @(posedge clk_i) begin
        if (rst_i || kill) begin
            rdy_q <= 1'b0;
        end else if (st_q == IBR_ST_IDLE) begin
            rdy_q <= busy_q && !take && !ovf;
        end else begin
            rdy_q <= 1'b0;
        end
    end

    // Fractional step gives 16 counts per 20 clocks, with phase jitter of one clock
    assign frac_sum = {1'b0, frac_q} + {1'b0, RANGE_STEP};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frac_q <= 5'h00;
        end else if (frac_sum >= {1'b0, RANGE_MOD}) begin
            frac_q <= 5'(frac_sum - {1'b0, RANGE_MOD});
        end else begin
            frac_q <= frac_sum[4:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            range_q <= '0;
        end else if (frac_sum >= {1'b0, RANGE_MOD}) begin
            range_q <= range_q + RANGE_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            intr_q <= 1'b0;
        end else begin
            intr_q <= (done_q || arr_q) && !idis_q;
        end
    end

    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = rdat_q;
    assign word_ready_o = rdy_q;
    assign dma_req_o    = req_q;
    assign dma_o        = dma_q;
    assign intr_o       = intr_q;
    assign skip_done_o  = done_q;
    assign interrupt_acknowledge_query_ident_o = ident_q;
    assign time_disc_o  = range_q[TIME_W-1:0];
    assign time_short_o = range_q[RANGE_W-1:RANGE_W-TIME_W];

endmodule : ibr_receiver_port

// >>> tb/ibr_receiver_port_chk.sv
`timescale 1ns/1ps
module ibr_receiver_port_chk (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic              system_io_reset_pulse_i,
    input wire logic              word_valid_i,
    input wire logic [15:0]       word_i,
    input wire logic              word_ready_o,
    input wire logic              dma_req_o,
    input wire ibr_pkg::ibr_dma_s dma_o,
    input wire logic              dma_ack_i,
    input wire logic              intr_o,
    input wire logic              skip_done_o,
    input wire logic              interrupt_acknowledge_query_ident_o,
    input wire logic [15:0]       time_disc_o,
    input wire logic [15:0]       time_short_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_req_hold: assert property (dma_req_o && !dma_ack_i && !system_io_reset_pulse_i
        |=> dma_req_o && $stable(dma_o))
        else $error("dma request dropped");
    a_req_release: assert property (dma_req_o && dma_ack_i |=> !dma_req_o)
        else $error("dma request stuck");
    a_word_capture: assert property (word_valid_i && word_ready_o && !system_io_reset_pulse_i
        |=> dma_req_o && dma_o.data == $past(word_i))
        else $error("word not forwarded");
    a_one_word: assert property (dma_req_o |-> !word_ready_o)
        else $error("ready during dma");
    a_skip_ident: assert property (skip_done_o |-> interrupt_acknowledge_query_ident_o)
        else $error("ident missing");
    a_intr_cause: assert property (intr_o |-> $past(interrupt_acknowledge_query_ident_o))
        else $error("interrupt without done");
    a_time_fields: assert property (time_short_o[11:0] == time_disc_o[15:4])
        else $error("time fields disagree");
    a_range_step: assert property (16'(time_disc_o - $past(time_disc_o)) <= 16'h0001)
        else $error("range counter jump");
    a_ioreset_stop: assert property (system_io_reset_pulse_i
        |-> ##3 !skip_done_o && !interrupt_acknowledge_query_ident_o && !dma_req_o && !intr_o)
        else $error("reset left state");
endmodule : ibr_receiver_port_chk

bind ibr_receiver_port ibr_receiver_port_chk u_chk (.*);

// >>> tb/ibr_mem_model.sv
`timescale 1ns/1ps
module ibr_mem_model (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              req_i,
    input  wire ibr_pkg::ibr_dma_s dma_i,
    input  wire logic [1:0]        slow_i,
    output logic                   ack_o
);
    logic [15:0] mem [0:65535];
    logic [1:0]  wait_q;

    // Ack is a single pulse; guard keeps one write per request
    always_ff @(posedge clk_i) begin
        ack_o <= 1'b0;
        if (rst_i) begin
            wait_q <= 2'h0;
        end else if (req_i && !ack_o) begin
            if (wait_q >= slow_i) begin
                ack_o <= 1'b1;
                mem[dma_i.addr] <= dma_i.data;
                wait_q <= 2'h0;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule : ibr_mem_model

// >>> tb/ibr_receiver_port_tb.sv
`timescale 1ns/1ps
module ibr_receiver_port_tb;
    import ibr_pkg::*;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, arrival_i;
    logic        system_io_reset_pulse_i, mask_out_i, word_valid_i, word_ready_o;
    logic        dma_req_o, dma_ack_i, intr_o, skip_done_o, interrupt_acknowledge_query_ident_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] mask_data_i, word_i, time_disc_o, time_short_o, org, t0;
    logic [15:0] wq [0:9];
    logic [1:0]  slow;
    ibr_dma_s    dma_o;
    int          errors, tests_run, seed;

    ibr_receiver_port u_ibr_receiver_port (.*);
    ibr_mem_model u_ibr_mem_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(dma_req_o),
        .dma_i(dma_o), .slow_i(slow), .ack_o(dma_ack_i));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic finish_test;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    initial begin
        repeat (40000) @(posedge clk_i);
        errors++;
        finish_test;
    end

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : cmp

    function automatic logic [31:0] st(input logic b, d, a, i);
        st = '0;
        st[STAT_BUSY_BIT] = b;
        st[STAT_DONE_BIT] = d;
        st[STAT_ARR_BIT] = a;
        st[STAT_IDIS_BIT] = i;
    endfunction : st

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0000_0000);
        cmp(nm, e, rd);
    endtask : rdx

    task automatic pulse(input int k);
        system_io_reset_pulse_i <= (k == 0);
        mask_out_i <= (k == 1);
        arrival_i <= (k == 2);
        @(posedge clk_i);
        {system_io_reset_pulse_i, mask_out_i, arrival_i} <= 3'h0;
        @(posedge clk_i);
    endtask : pulse

    // Holds valid until taken, then waits out the memory write
    task automatic put(input logic [15:0] w);
        int n;
        n = 0;
        word_valid_i <= 1'b1;
        word_i <= w;
        do begin
            @(posedge clk_i);
            n++;
        end while (word_ready_o !== 1'b1 && n < 50);
        word_valid_i <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (dma_req_o === 1'b1 && n < 50);
        if (n >= 50) errors++;
        slow <= 2'($random(seed));
    endtask : put

    task automatic blk(input int f, input int t);
        for (int i = f; i < t; i++) begin
            wq[i] = 16'($random(seed));
            put(wq[i]);
        end
    endtask : blk

    task automatic mask(input logic v);
        mask_data_i <= (16'($random(seed)) & ~16'h0020) | {10'h000, v, 5'h00};
        pulse(1);
    endtask : mask

    initial begin
        seed = 32'h81d0;
        {wb_cyc_i, wb_stb_i, wb_we_i, arrival_i, mask_out_i, word_valid_i} = '0;
        {wb_adr_i, wb_dat_i, mask_data_i, word_i, slow} = '0;
        system_io_reset_pulse_i = 1'b0;
        wb_sel_i = 4'hF;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        org = 16'($random(seed)) & 16'hF000;
        pulse(0);
        t0 = time_disc_o;
        repeat (20) @(posedge clk_i);
        cmp("range", {16'h0, 16'(t0 + 16'h0010)}, {16'h0, time_disc_o});
        cmp("short", {20'h0, time_disc_o[15:4]}, {16'h0, time_short_o});
        wb(1'b1, OFS_C_PORT, 32'hFFFF_FFFF);
        rdx(OFS_C_PORT, 32'h0000_0000, "cnt_zero");
        wb(1'b1, 8'h0C, 32'h0000_0001);
        rdx(8'h0C, 32'h0000_0000, "unmapped");
        rdx(OFS_CTRL, st(0, 0, 0, 0), "idle");
        wb(1'b1, OFS_A_PORT, {16'h0000, org});
        wb(1'b1, OFS_CTRL, 32'h0000_0001);
        rdx(OFS_CTRL, st(1, 0, 0, 0), "start");
        rdx(OFS_A_PORT, {16'h0000, org}, "origin");
        pulse(2);
        rdx(OFS_CTRL, st(1, 0, 1, 0), "arrival");
        cmp("intr", 32'h1, {31'h0, intr_o});
        cmp("skip", 32'h0, {31'h0, skip_done_o});
        cmp("ident", 32'h1, {31'h0, interrupt_acknowledge_query_ident_o});
        wb(1'b1, OFS_CTRL, 32'h0000_0004);
        rdx(OFS_CTRL, st(1, 0, 0, 0), "p_clear");
        cmp("ident_off", 32'h0, {31'h0, interrupt_acknowledge_query_ident_o});
        blk(0, 9);
        rdx(OFS_C_PORT, 32'h0000_0000, "cnt9");
        blk(9, 10);
        rdx(OFS_C_PORT, 32'h0000_0001, "cnt10");
        for (int i = 0; i < 10; i++) cmp("mem", {16'h0, wq[i]}, u_ibr_mem_model.mem[org + i]);
        rdx(OFS_A_PORT, {16'h0000, org + 16'h000A}, "next_adr");
        repeat (63) blk(0, 10);
        for (int i = 0; i < 10; i++) cmp("wrap", {16'h0, wq[i]}, u_ibr_mem_model.mem[org + 630 + i]);
        rdx(OFS_A_PORT, {16'h0000, org}, "wrap_adr");
        rdx(OFS_C_PORT, 32'h0000_0040, "cnt64");
        rdx(OFS_CTRL, st(0, 1, 0, 0), "ovf");
        cmp("ovf_ready", 32'h0, {31'h0, word_ready_o});
        cmp("ovf_skip", 32'h1, {31'h0, skip_done_o});
        mask(1'b1);
        rdx(OFS_CTRL, st(0, 1, 0, 1), "mask1");
        cmp("intr_off", 32'h0, {31'h0, intr_o});
        mask(1'b0);
        rdx(OFS_CTRL, st(0, 1, 0, 0), "mask0");
        cmp("intr_on", 32'h1, {31'h0, intr_o});
        wb(1'b1, OFS_C_PORT, $random(seed));
        rdx(OFS_C_PORT, 32'h0000_003F, "dec");
        wb(1'b1, OFS_CTRL, 32'h0000_0002);
        rdx(OFS_CTRL, st(0, 0, 0, 0), "clear");
        rdx(OFS_C_PORT, 32'h0000_0000, "clr_cnt");
        wb(1'b1, OFS_CTRL, 32'h0000_0001);
        blk(0, 3);
        wb(1'b1, OFS_CTRL, 32'h0000_0002);
        wb(1'b1, OFS_CTRL, 32'h0000_0001);
        rdx(OFS_A_PORT, {16'h0000, org}, "reload");
        mask(1'b1);
        pulse(0);
        rdx(OFS_CTRL, st(0, 0, 0, 0), "system_io_reset_pulse");
        finish_test;
    end
endmodule : ibr_receiver_port_tb
